// ### src/dab_transfer_controller.sv
module dab_transfer_controller #(
   parameter int NUM_CH = 4,
   parameter int PIN_CH = 2,
   parameter int CNT_W = 16
)(
   // Clock, reset and enable
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   // Register port
   input wire logic [dab_pkg::RADDR_W-1:0] REG_ADDR_IN,
   input wire logic [dab_pkg::DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [dab_pkg::DATA_W-1:0] REG_RDATA_OUT,
   // Transfer triggers
   input wire logic [PIN_CH-1:0] TRANSFER_REQUEST_PIN_N_IN,
   input wire logic SERIAL_REQ_IN,
   input wire logic ADC_REQ_IN,
   input wire logic PERIPH_REQ_IN,
   // Bus master
   output logic BUS_REQ_OUT,
   input wire logic BUS_GRANT_IN,
   input wire logic BUS_DONE_IN,
   input wire logic [dab_pkg::DATA_W-1:0] BUS_RDATA_IN,
   output dab_pkg::dab_cmd_s BUS_CMD_OUT,
   // Acknowledge
   output logic [NUM_CH-1:0] TRANSFER_ACK_STROBE_OUT,
   output logic ACK_WRITE_OUT
);
   initial
   begin
      if (NUM_CH < 2 || NUM_CH > 4 || PIN_CH < 1 || PIN_CH > 2 || CNT_W < 1 || CNT_W > 32)
      begin
         $error("dab_transfer_controller: unsupported parameters");
      end
   end

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_GRANT,
      ST_READ,
      ST_WRITE,
      ST_SINGLE,
      ST_RELEASE
   } dab_state_e;

   typedef logic [dab_pkg::CTRL_W-1:0] dab_ctrl_t;

   dab_ctrl_t ctrl [NUM_CH];
   logic [dab_pkg::ADDR_W-1:0] src [NUM_CH];
   logic [dab_pkg::ADDR_W-1:0] dst [NUM_CH];
   logic [CNT_W-1:0] cnt [NUM_CH];
   logic [NUM_CH-1:0] done;
   logic [NUM_CH-1:0] pend;
   logic [PIN_CH-1:0] pin_q1;
   logic [PIN_CH-1:0] pin_q2;
   logic [NUM_CH-1:0] pin_act;
   logic [NUM_CH-1:0] trig;
   logic [NUM_CH-1:0] ready;
   logic [NUM_CH-1:0] cfg_err;
   logic [NUM_CH-1:0] busy;
   logic [1:0] pick;
   logic any_ready;
   dab_state_e state;
   logic [1:0] cur;
   logic [dab_pkg::DATA_W-1:0] hold;
   logic unit_done;
   logic cont;
   logic [CNT_W-1:0] cnt_next;
   logic [dab_pkg::DATA_W-1:0] rd_val;

   function automatic dab_pkg::dab_req_e req_of(input dab_ctrl_t c);
      return dab_pkg::dab_req_e'(c[dab_pkg::F_REQ +: 3]);
   endfunction : req_of

   // A channel whose setup breaks a restriction never starts; software sees it in status.
   function automatic logic cfg_ok(input int ch, input dab_ctrl_t c);
      dab_pkg::dab_req_e r;
      logic ok;
      r = req_of(c);
      ok = 1'b1;
      if (r > dab_pkg::REQ_PERIPH)
      begin
         ok = 1'b0;
      end
      if (c[dab_pkg::F_SINGLE] && (r != dab_pkg::REQ_PIN))
      begin
         ok = 1'b0;
      end
      if ((r == dab_pkg::REQ_PIN) && (ch >= PIN_CH))
      begin
         ok = 1'b0;
      end
      if ((r == dab_pkg::REQ_SERIAL || r == dab_pkg::REQ_ADC) &&
          !(c[dab_pkg::F_SRC_REQ] || c[dab_pkg::F_DST_REQ]))
      begin
         ok = 1'b0;
      end
      return ok;
   endfunction : cfg_ok

   // A serial requester cannot hold the bus, so burst is overridden.
   function automatic logic burst_eff(input dab_ctrl_t c);
      return c[dab_pkg::F_BURST] && (req_of(c) != dab_pkg::REQ_SERIAL);
   endfunction : burst_eff

   function automatic logic [dab_pkg::ADDR_W-1:0] step(input logic [dab_pkg::ADDR_W-1:0] a,
                                                       input logic word);
      return word ? a + 32'h0000_0002 : a + 32'h0000_0001;
   endfunction : step

   // First access of a unit: single address uses one access, dual starts with the read.
   function automatic dab_pkg::dab_cmd_s first_cmd(input dab_ctrl_t c,
                                                   input logic [dab_pkg::ADDR_W-1:0] s,
                                                   input logic [dab_pkg::ADDR_W-1:0] d);
      dab_pkg::dab_cmd_s k;
      k = dab_pkg::CMD_IDLE;
      k.word = c[dab_pkg::F_WORD];
      if (c[dab_pkg::F_SINGLE] && c[dab_pkg::F_TO_MEM])
      begin
         k.wr = 1'b1;
         k.addr = d;
      end
      else
      begin
         k.rd = 1'b1;
         k.addr = s;
      end
      return k;
   endfunction : first_cmd

   // Pin synchroniser; the first stage feeds only the second.
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         pin_q1 <= '1;
         pin_q2 <= '1;
      end
      else if (CE_IN)
      begin
         pin_q1 <= TRANSFER_REQUEST_PIN_N_IN;
         pin_q2 <= pin_q1;
      end
   end

   always_comb
   begin
      pin_act = '0;
      for (int i = 0; i < PIN_CH; i++)
      begin
         pin_act[i] = !pin_q2[i];
      end
      for (int c = 0; c < NUM_CH; c++)
      begin
         case (req_of(ctrl[c]))
            dab_pkg::REQ_AUTO: trig[c] = 1'b1;
            dab_pkg::REQ_PIN: trig[c] = pin_act[c];
            default: trig[c] = pend[c];
         endcase
         cfg_err[c] = ctrl[c][dab_pkg::F_EN] && !cfg_ok(c, ctrl[c]);
         ready[c] = ctrl[c][dab_pkg::F_EN] && !cfg_err[c] && (cnt[c] != '0) && trig[c];
         busy[c] = (state != ST_IDLE) && (cur == 2'(c));
      end
      pick = 2'h0;
      any_ready = |ready;
      for (int c = NUM_CH - 1; c >= 0; c--)
      begin
         if (ready[c])
         begin
            pick = 2'(c);
         end
      end
   end

   // Peripheral request pulses are latched; a pulse in the clearing cycle survives.
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         pend <= '0;
      end
      else if (CE_IN)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            pend[c] <= ((req_of(ctrl[c]) == dab_pkg::REQ_SERIAL) && SERIAL_REQ_IN) ||
                       ((req_of(ctrl[c]) == dab_pkg::REQ_ADC) && ADC_REQ_IN) ||
                       ((req_of(ctrl[c]) == dab_pkg::REQ_PERIPH) && PERIPH_REQ_IN) ||
                       (pend[c] && !(unit_done && cur == 2'(c)));
         end
      end
   end

   assign unit_done = ((state == ST_WRITE) || (state == ST_SINGLE)) && BUS_DONE_IN;
   assign cnt_next = cnt[cur] - CNT_W'(1);
   // Burst keeps going; a pin-triggered burst stops at the end of the first unit that ends with the synchronised pin released.
   assign cont = burst_eff(ctrl[cur]) && ctrl[cur][dab_pkg::F_EN] && (cnt_next != '0) &&
                 ((req_of(ctrl[cur]) != dab_pkg::REQ_PIN) || pin_act[cur]);

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         state <= ST_IDLE;
         cur <= 2'h0;
         hold <= '0;
         BUS_REQ_OUT <= 1'b0;
         BUS_CMD_OUT <= dab_pkg::CMD_IDLE;
      end
      else if (CE_IN)
      begin
         case (state)
            ST_IDLE:
            begin
               if (any_ready)
               begin
                  cur <= pick;
                  BUS_REQ_OUT <= 1'b1;
                  state <= ST_GRANT;
               end
            end
            ST_GRANT:
            begin
               if (BUS_GRANT_IN)
               begin
                  BUS_CMD_OUT <= first_cmd(ctrl[cur], src[cur], dst[cur]);
                  state <= ctrl[cur][dab_pkg::F_SINGLE] ? ST_SINGLE : ST_READ;
               end
            end
            ST_READ:
            begin
               if (BUS_DONE_IN)
               begin
                  hold <= BUS_RDATA_IN;
                  BUS_CMD_OUT.rd <= 1'b0;
                  BUS_CMD_OUT.wr <= 1'b1;
                  BUS_CMD_OUT.addr <= dst[cur];
                  BUS_CMD_OUT.wdata <= BUS_RDATA_IN;
                  state <= ST_WRITE;
               end
            end
            ST_WRITE, ST_SINGLE:
            begin
               if (BUS_DONE_IN)
               begin
                  if (cont)
                  begin
                     BUS_CMD_OUT <= first_cmd(ctrl[cur], step(src[cur], ctrl[cur][dab_pkg::F_WORD]),
                                              step(dst[cur], ctrl[cur][dab_pkg::F_WORD]));
                     if (!ctrl[cur][dab_pkg::F_SRC_INC])
                     begin
                        BUS_CMD_OUT.addr <= ctrl[cur][dab_pkg::F_SINGLE] && ctrl[cur][dab_pkg::F_TO_MEM] &&
                                            ctrl[cur][dab_pkg::F_DST_INC] ?
                                            step(dst[cur], ctrl[cur][dab_pkg::F_WORD]) :
                                            (ctrl[cur][dab_pkg::F_SINGLE] && ctrl[cur][dab_pkg::F_TO_MEM] ?
                                             dst[cur] : src[cur]);
                     end
                     else if (ctrl[cur][dab_pkg::F_SINGLE] && ctrl[cur][dab_pkg::F_TO_MEM] &&
                              !ctrl[cur][dab_pkg::F_DST_INC])
                     begin
                        BUS_CMD_OUT.addr <= dst[cur];
                     end
                     state <= ctrl[cur][dab_pkg::F_SINGLE] ? ST_SINGLE : ST_READ;
                  end
                  else
                  begin
                     BUS_CMD_OUT <= dab_pkg::CMD_IDLE;
                     BUS_REQ_OUT <= 1'b0;
                     state <= ST_RELEASE;
                  end
               end
            end
            ST_RELEASE:
            begin
               state <= ST_IDLE;
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Ack goes with the access: single address always, dual only in the chosen cycle.
   always_comb
   begin
      TRANSFER_ACK_STROBE_OUT = '0;
      if ((state == ST_SINGLE) ||
          (state == ST_READ && !ctrl[cur][dab_pkg::F_ACK_WR]) ||
          (state == ST_WRITE && ctrl[cur][dab_pkg::F_ACK_WR]))
      begin
         TRANSFER_ACK_STROBE_OUT[cur] = 1'b1;
      end
      ACK_WRITE_OUT = (state == ST_SINGLE) ? ctrl[cur][dab_pkg::F_TO_MEM] : (state == ST_WRITE);
   end

   // Channel registers: software writes win over the engine's own update, except that a done set by the engine wins over the clearing count write.
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            ctrl[c] <= dab_pkg::CTRL_RST;
            src[c] <= dab_pkg::ADDR_RST;
            dst[c] <= dab_pkg::ADDR_RST;
            cnt[c] <= '0;
         end
         done <= '0;
      end
      else if (CE_IN)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (unit_done && cur == 2'(c))
            begin
               cnt[c] <= cnt_next;
               if (ctrl[c][dab_pkg::F_SRC_INC])
               begin
                  src[c] <= step(src[c], ctrl[c][dab_pkg::F_WORD]);
               end
               if (ctrl[c][dab_pkg::F_DST_INC])
               begin
                  dst[c] <= step(dst[c], ctrl[c][dab_pkg::F_WORD]);
               end
            end
            if (REG_WR_IN && REG_ADDR_IN[7:6] == 2'h0 && REG_ADDR_IN[5:4] == 2'(c))
            begin
               if (REG_ADDR_IN[3:0] == dab_pkg::OFF_CTRL)
               begin
                  ctrl[c] <= REG_WDATA_IN[dab_pkg::CTRL_W-1:0];
               end
               else if (REG_ADDR_IN[3:0] == dab_pkg::OFF_SRC)
               begin
                  src[c] <= REG_WDATA_IN;
               end
               else if (REG_ADDR_IN[3:0] == dab_pkg::OFF_DST)
               begin
                  dst[c] <= REG_WDATA_IN;
               end
               else if (REG_ADDR_IN[3:0] == dab_pkg::OFF_CNT)
               begin
                  cnt[c] <= REG_WDATA_IN[CNT_W-1:0];
               end
            end
            done[c] <= (unit_done && cur == 2'(c) && cnt_next == '0) ||
                       (done[c] && !(REG_WR_IN && REG_ADDR_IN == (8'(c) << 4 | 8'(dab_pkg::OFF_CNT))));
         end
      end
   end

   always_comb
   begin
      rd_val = '0;
      if (REG_ADDR_IN == dab_pkg::OFF_STATUS)
      begin
         rd_val[dab_pkg::S_DONE +: NUM_CH] = done;
         rd_val[dab_pkg::S_ERR +: NUM_CH] = cfg_err;
         rd_val[dab_pkg::S_BUSY +: NUM_CH] = busy;
      end
      else if (REG_ADDR_IN[7:6] == 2'h0 && 32'(REG_ADDR_IN[5:4]) < NUM_CH)
      begin
         if (REG_ADDR_IN[3:0] == dab_pkg::OFF_CTRL)
         begin
            rd_val = 32'(ctrl[REG_ADDR_IN[5:4]]);
         end
         else if (REG_ADDR_IN[3:0] == dab_pkg::OFF_SRC)
         begin
            rd_val = src[REG_ADDR_IN[5:4]];
         end
         else if (REG_ADDR_IN[3:0] == dab_pkg::OFF_DST)
         begin
            rd_val = dst[REG_ADDR_IN[5:4]];
         end
         else if (REG_ADDR_IN[3:0] == dab_pkg::OFF_CNT)
         begin
            rd_val = 32'(cnt[REG_ADDR_IN[5:4]]);
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         REG_RDATA_OUT <= '0;
      end
      else if (CE_IN)
      begin
         REG_RDATA_OUT <= REG_RD_IN ? rd_val : '0;
      end
   end

   default clocking dab_cb @(posedge CLK_IN iff CE_IN);
   endclocking
   default disable iff (!RST_N_IN);

   single_ack_addr_a: assert property ((state == ST_SINGLE) |->
      TRANSFER_ACK_STROBE_OUT[cur] && (BUS_CMD_OUT.rd ^ BUS_CMD_OUT.wr))
      else $error("single access without ack and address");
   single_no_second_a: assert property ((state == ST_SINGLE && BUS_DONE_IN) |=>
      (state == ST_SINGLE || state == ST_RELEASE))
      else $error("single address used a second cycle");
   ack_waveform_a: assert property ((state == ST_SINGLE) |->
      (ACK_WRITE_OUT == BUS_CMD_OUT.wr) && (BUS_CMD_OUT.wr == ctrl[cur][dab_pkg::F_TO_MEM]))
      else $error("ack waveform does not follow direction");
   single_am_ignored_a: assert property ((state == ST_SINGLE && ctrl[cur][dab_pkg::F_ACK_WR] == 1'b1)
      |-> TRANSFER_ACK_STROBE_OUT[cur])
      else $error("ack timing select affected single mode");
   dual_read_write_a: assert property ((state == ST_READ && BUS_DONE_IN) |=>
      (state == ST_WRITE) && BUS_CMD_OUT.wr && (BUS_CMD_OUT.wdata == $past(BUS_RDATA_IN)))
      else $error("dual write did not carry read data");
   dual_ack_cycle_a: assert property ((state == ST_READ || state == ST_WRITE) |->
      (TRANSFER_ACK_STROBE_OUT[cur] == ((state == ST_WRITE) == ctrl[cur][dab_pkg::F_ACK_WR])))
      else $error("dual ack in wrong cycle");
   steal_release_a: assert property ((unit_done && !burst_eff(ctrl[cur])) |=> !BUS_REQ_OUT ##1
      (state == ST_IDLE))
      else $error("cycle steal kept the bus");
   burst_hold_a: assert property ((unit_done && cont) |=> BUS_REQ_OUT && (state != ST_RELEASE))
      else $error("burst released the bus early");
   pin_release_a: assert property ((unit_done && req_of(ctrl[cur]) == dab_pkg::REQ_PIN &&
      !pin_act[cur]) |=> !BUS_REQ_OUT)
      else $error("bus kept after pin release");
   serial_steal_a: assert property ((unit_done && req_of(ctrl[cur]) == dab_pkg::REQ_SERIAL)
      |=> !BUS_REQ_OUT)
      else $error("serial channel held bus");
   pin_channel_a: assert property ((state == ST_GRANT) |->
      !(req_of(ctrl[cur]) == dab_pkg::REQ_PIN && 32'(cur) >= PIN_CH))
      else $error("pin request served on high channel");
   unit_size_a: assert property ((BUS_CMD_OUT.rd || BUS_CMD_OUT.wr) |->
      (BUS_CMD_OUT.word == ctrl[cur][dab_pkg::F_WORD]))
      else $error("access width differs from unit size");

   single_done_c: cover property (state == ST_SINGLE && BUS_DONE_IN);
   dual_done_c: cover property (state == ST_WRITE && BUS_DONE_IN);
   burst_go_c: cover property (unit_done && cont);
   steal_go_c: cover property (unit_done && !cont ##1 state == ST_RELEASE);
endmodule : dab_transfer_controller

// ### src/dab_pkg.sv
package dab_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int RADDR_W = 8;
   localparam int CTRL_W = 13;
   // Register offsets; channel n sits at n * CH_STRIDE.
   localparam logic [7:0] CH_STRIDE = 8'h10;
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_SRC = 4'h4;
   localparam logic [3:0] OFF_DST = 4'h8;
   localparam logic [3:0] OFF_CNT = 4'hC;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   // Channel control fields.
   localparam int F_EN = 0;
   localparam int F_SINGLE = 1;
   localparam int F_BURST = 2;
   localparam int F_WORD = 3;
   localparam int F_REQ = 4;
   localparam int F_ACK_WR = 7;
   localparam int F_TO_MEM = 8;
   localparam int F_SRC_INC = 9;
   localparam int F_DST_INC = 10;
   localparam int F_SRC_REQ = 11;
   localparam int F_DST_REQ = 12;
   // Status fields.
   localparam int S_DONE = 0;
   localparam int S_ERR = 8;
   localparam int S_BUSY = 16;
   // Reset values.
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   typedef enum logic [2:0]
   {
      REQ_AUTO,
      REQ_PIN,
      REQ_SERIAL,
      REQ_ADC,
      REQ_PERIPH
   } dab_req_e;
   typedef struct packed
   {
      logic rd;
      logic wr;
      logic word;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dab_cmd_s;
   localparam dab_cmd_s CMD_IDLE = '0;
endpackage : dab_pkg

// ### tb/dab_bus_model.sv
module dab_bus_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Extra wait cycles per access
   input wire logic [1:0] slow_in,
   // Controller side
   input wire logic bus_req_in,
   input wire dab_pkg::dab_cmd_s cmd_in,
   output logic grant_out,
   output logic done_out,
   output logic [dab_pkg::DATA_W-1:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt;
   always_ff @(posedge clk_in or negedge rst_n_in)
      if (!rst_n_in)
         grant_out <= 1'b0;
      else
         grant_out <= bus_req_in;
   // Read data is only good in the done cycle; it toggles elsewhere so a stale capture shows.
   always_ff @(posedge clk_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         cnt <= 2'h0;
         done_out <= 1'b0;
         rdata_out <= 32'h0;
      end
      else
      begin
         rdata_out <= ~rdata_out;
         if (done_out)
         begin
            cnt <= 2'h0;
            done_out <= 1'b0;
         end
         else if (cmd_in.rd || cmd_in.wr)
         begin
            cnt <= cnt + 2'h1;
            done_out <= (cnt == slow_in);
            if (cnt == slow_in)
               rdata_out <= cmd_in.addr ^ 32'h5A5A_0000;
         end
      end
endmodule : dab_bus_model

// ### tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] ra = 8'h00;
   logic [31:0] rwd = 32'h0;
   logic rw = 1'b0;
   logic rr = 1'b0;
   logic [31:0] rdat;
   logic [1:0] pin_n = 2'h3;
   logic ser = 1'b0;
   logic adc = 1'b0;
   logic per = 1'b0;
   logic [1:0] slow = 2'h0;
   logic breq, gnt, bdone, ackw, prev_breq;
   logic [31:0] brd;
   logic [3:0] ack;
   dab_pkg::dab_cmd_s cmd;
   logic [71:0] acc_q[$];
   int errors = 0;
   int n_compared = 0;
   int rel = 0;
   logic [40:0] rows [9] = '{{1'b0, 8'h40, 32'h0}, {1'b0, 8'h00, 32'h0}, {1'b0, 8'h34, 32'h0},
      {1'b1, 8'h3C, 32'hFFFFFFFF}, {1'b0, 8'h3C, 32'h0000FFFF}, {1'b1, 8'h10, 32'hFFFFFFFE},
      {1'b0, 8'h10, 32'h00001FFE}, {1'b1, 8'h44, 32'h12345678}, {1'b0, 8'h44, 32'h0}};
   dab_transfer_controller uut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1), .REG_ADDR_IN(ra),
      .REG_WDATA_IN(rwd), .REG_WR_IN(rw), .REG_RD_IN(rr), .REG_RDATA_OUT(rdat),
      .TRANSFER_REQUEST_PIN_N_IN(pin_n), .SERIAL_REQ_IN(ser), .ADC_REQ_IN(adc), .PERIPH_REQ_IN(per),
      .BUS_REQ_OUT(breq), .BUS_GRANT_IN(gnt), .BUS_DONE_IN(bdone), .BUS_RDATA_IN(brd),
      .BUS_CMD_OUT(cmd), .TRANSFER_ACK_STROBE_OUT(ack), .ACK_WRITE_OUT(ackw));
   dab_bus_model bus (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .bus_req_in(breq), .cmd_in(cmd),
      .grant_out(gnt), .done_out(bdone), .rdata_out(brd));
   initial
      forever #50 clk = ~clk;
   // Every finished access is logged with the strobes seen beside it.
   always @(posedge clk)
   begin
      if (bdone && (cmd.rd || cmd.wr))
         acc_q.push_back({ack, ackw, cmd.rd, cmd.wr, cmd.word, cmd.addr, cmd.wdata});
      if (!breq && prev_breq)
         rel++;
      prev_breq = breq;
   end
   task automatic final_report;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      n_compared++;
      if (g !== x)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      ra <= a;
      rwd <= d;
      rw <= 1'b1;
      @(posedge clk);
      rw <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      @(posedge clk);
      ra <= a;
      rr <= 1'b1;
      @(posedge clk);
      rr <= 1'b0;
      #1 chk(rdat & m, x, "register read");
   endtask : rd_reg
   task automatic setup(input logic [7:0] b, input logic [31:0] c, input logic [31:0] s,
      input logic [31:0] d, input logic [31:0] n);
      acc_q.delete();
      rel = 0;
      wr_reg(b + 8'h04, s);
      wr_reg(b + 8'h08, d);
      wr_reg(b + 8'h0C, n);
      wr_reg(b, c);
   endtask : setup
   task automatic wait_acc(input int n);
      int i;
      for (i = 0; i < 400 && acc_q.size() < n; i++)
         @(posedge clk);
      if (i == 400)
      begin
         errors++;
         $display("mismatch at %0t: transfer timeout", $time);
         final_report();
      end
      repeat (4) @(posedge clk);
   endtask : wait_acc
   // Flag cw: bit 1 marks a single address access, whose direction waveform is checked.
   task automatic chk_acc(input logic [3:0] ak, input logic isrd, input logic [31:0] a,
      input logic [15:0] wd, input logic w, input logic [1:0] cw);
      logic [71:0] e;
      e = acc_q.pop_front();
      chk(e[71:68], ak, "ack strobe");
      chk(e[66:65], {isrd, ~isrd}, "direction");
      chk(e[64], w, "unit size");
      chk(e[63:32], a, "address");
      if (cw[1])
         chk(e[67], cw[0], "ack waveform");
      else if (!isrd)
         chk(e[15:0] & (w ? 16'hFFFF : 16'h00FF), wd, "write data");
   endtask : chk_acc
   task automatic pulse(input logic s, input logic a);
      @(posedge clk);
      ser <= s;
      adc <= a;
      @(posedge clk);
      ser <= 1'b0;
      adc <= 1'b0;
   endtask : pulse
   initial
   begin
      repeat (10) @(posedge clk);
      chk({breq, cmd, ack, ackw, rdat} == '0, 1'b1, "outputs in reset");
      rst_n <= 1'b1;
      foreach (rows[i])
         if (rows[i][40])
            wr_reg(rows[i][39:32], rows[i][31:0]);
         else
            rd_reg(rows[i][39:32], rows[i][31:0], 32'hFFFFFFFF);
      setup(8'h20, 32'h0689, 32'h100, 32'h200, 2);
      wait_acc(4);
      chk_acc(4'h0, 1'b1, 32'h100, 16'h0, 1'b1, 2'b00);
      chk_acc(4'h4, 1'b0, 32'h200, 16'h0100, 1'b1, 2'b00);
      chk_acc(4'h0, 1'b1, 32'h102, 16'h0, 1'b1, 2'b00);
      chk_acc(4'h4, 1'b0, 32'h202, 16'h0102, 1'b1, 2'b00);
      chk(rel, 2, "cycle steal releases");
      slow <= 2'h2;
      setup(8'h30, 32'h0205, 32'h300, 32'h400, 2);
      wait_acc(4);
      chk_acc(4'h8, 1'b1, 32'h300, 16'h0, 1'b0, 2'b00);
      chk_acc(4'h0, 1'b0, 32'h400, 16'h0000, 1'b0, 2'b00);
      chk_acc(4'h8, 1'b1, 32'h301, 16'h0, 1'b0, 2'b00);
      chk_acc(4'h0, 1'b0, 32'h400, 16'h0001, 1'b0, 2'b00);
      chk(rel, 1, "burst releases");
      rd_reg(8'h40, 32'h0000000C, 32'h0000000F);
      slow <= 2'h0;
      pin_n <= 2'b10;
      setup(8'h00, 32'h0597, 32'h0, 32'h500, 2);
      wait_acc(2);
      pin_n <= 2'b11;
      chk_acc(4'h1, 1'b0, 32'h500, 16'h0, 1'b0, 2'b11);
      chk_acc(4'h1, 1'b0, 32'h501, 16'h0, 1'b0, 2'b11);
      pin_n <= 2'b01;
      setup(8'h10, 32'h0293, 32'h600, 32'h0, 1);
      wait_acc(1);
      pin_n <= 2'b11;
      chk_acc(4'h2, 1'b1, 32'h600, 16'h0, 1'b0, 2'b10);
      slow <= 2'h3;
      pin_n <= 2'b10;
      setup(8'h00, 32'h0597, 32'h0, 32'h700, 8);
      wait_acc(1);
      pin_n <= 2'b11;
      repeat (40) @(posedge clk);
      chk(acc_q.size() > 0 && acc_q.size() < 8, 1'b1, "burst stop on pin");
      chk(breq, 1'b0, "bus left after pin");
      wr_reg(8'h00, 32'h0);
      slow <= 2'h0;
      setup(8'h10, 32'h082D, 32'h800, 32'h900, 2);
      pulse(1'b1, 1'b0);
      repeat (20) @(posedge clk);
      pulse(1'b1, 1'b0);
      repeat (20) @(posedge clk);
      chk(acc_q.size(), 4, "serial units");
      chk(rel, 2, "serial burst as steal");
      chk_acc(4'h2, 1'b1, 32'h800, 16'h0, 1'b1, 2'b00);
      // Channels 2 and 3 still hold auto setups; a count write would start them at once.
      wr_reg(8'h20, 32'h0);
      wr_reg(8'h30, 32'h0);
      setup(8'h20, 32'h0041, 32'hA00, 32'hB00, 1);
      setup(8'h30, 32'h0831, 32'hC00, 32'hD00, 1);
      repeat (10) @(posedge clk);
      chk(acc_q.size(), 0, "no start before request");
      per <= 1'b1;
      adc <= 1'b1;
      @(posedge clk);
      per <= 1'b0;
      adc <= 1'b0;
      wait_acc(4);
      chk_acc(4'h4, 1'b1, 32'hA00, 16'h0, 1'b0, 2'b00);
      chk_acc(4'h0, 1'b0, 32'hB00, 16'h0000, 1'b0, 2'b00);
      chk_acc(4'h8, 1'b1, 32'hC00, 16'h0, 1'b0, 2'b00);
      chk_acc(4'h0, 1'b0, 32'hD00, 16'h0000, 1'b0, 2'b00);
      setup(8'h20, 32'h0011, 32'h0, 32'h0, 1);
      setup(8'h30, 32'h0031, 32'h0, 32'h0, 1);
      setup(8'h00, 32'h0003, 32'h0, 32'h0, 1);
      setup(8'h10, 32'h0021, 32'h0, 32'h0, 1);
      pin_n <= 2'b00;
      pulse(1'b1, 1'b1);
      repeat (20) @(posedge clk);
      chk(acc_q.size(), 0, "refused configs");
      rd_reg(8'h40, 32'h00000F00, 32'h00000F00);
      rst_n <= 1'b0;
      @(posedge clk);
      #1 chk({breq, cmd, ack, ackw, rdat} == '0, 1'b1, "outputs in second reset");
      @(posedge clk);
      pin_n <= 2'b11;
      rst_n <= 1'b1;
      rd_reg(8'h40, 32'h0, 32'hFFFFFFFF);
      final_report();
   end
endmodule : tb_top
